// ==== sph_pkg.sv ====
// Purpose: constants and types for the servo positioning handshake block
// Assumes: 250 MHz pclk, APB register access, speeds in r/min
// Notes: all offsets, reset values and cycle counts live here
package sph_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SPH_OFS_THRESH = 8'h00;
  localparam logic [7:0] SPH_OFS_SETTLE = 8'h04;
  localparam logic [7:0] SPH_OFS_COARSE = 8'h08;
  localparam logic [7:0] SPH_OFS_STATUS = 8'h0c;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [15:0] SPH_THRESH_RST = 16'h0032; // 50 r/min
  localparam logic [15:0] SPH_HYST = 16'h0014; // 20 r/min
  localparam logic [15:0] SPH_SETTLE_RST = 16'h0064; // pulses
  localparam logic [15:0] SPH_COARSE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SPH_CLK_MHZ = 250;
  localparam int SPH_INDEX_US = 400;
  localparam int SPH_INDEX_CYC = SPH_INDEX_US * SPH_CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPH_IDLE = 3'b001,
    SPH_RUN = 3'b010,
    SPH_HALT = 3'b100
  } sph_state_t;

  // Status flags reported to the host
  typedef struct packed {
    logic settled;
    logic coarse;
    logic done;
    logic standstill;
  } sph_flags_t;

endpackage

// ==== sph_positioning.sv ====
// Purpose: start handshake, status flags and encoder pulse outputs
// Assumes: motion loop on pclk supplies speed, deviation, remaining
// Notes: zero-wait APB slave; unmapped address answers pslverr

`timescale 1ns/1ps

module sph_positioning
  import sph_pkg::*;
#(
  parameter int INDEX_CYC = SPH_INDEX_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fwd_start_cmd,
  input wire logic rev_start_cmd,
  input wire logic pause_restart_cmd,
  input wire logic main_power_ok,
  input wire logic servo_on,
  input wire logic forced_stop_input,
  input wire logic alarm_active,
  input wire logic signed [15:0] motor_speed,
  input wire logic [15:0] pos_deviation,
  input wire logic [15:0] remain_dist,
  input wire logic move_finished,
  input wire logic gain_change_busy,
  input wire logic enc_step,
  input wire logic enc_ccw,
  input wire logic enc_zero,
  output logic start_fwd,
  output logic start_rev,
  output logic pause_toggle,
  output logic busy,
  output logic standstill_flag,
  output logic gain_switch_active,
  output logic coarse_match_flag,
  output logic move_done_flag,
  output logic position_settled,
  output logic quad_a_out,
  output logic quad_a_out_n,
  output logic quad_b_out,
  output logic quad_b_out_n,
  output logic index_pulse_out,
  output logic index_pulse_out_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Magnitude of a signed speed, saturating at the negative limit
  function automatic logic [15:0] sph_abs(input logic signed [15:0] v);
    logic [15:0] m;
    m = 16'h0000;
    if (v == 16'sh8000)
      m = 16'h7fff;
    else if (v < 0)
      m = 16'(-v);
    else
      m = 16'(v);
    return m;
  endfunction

  // Distance within a range
  function automatic logic sph_within(input logic [15:0] d,
                                      input logic [15:0] lim);
    return d <= lim;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_r; // First stage, read only by second
  logic [5:0] sync2_r; // Usable copies
  logic fwd_q_r; // Previous fwd level
  logic rev_q_r; // Previous rev level
  logic pause_q_r; // Previous pause level

  // Two flops for every asynchronous pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= {alarm_active, forced_stop_input, servo_on,
                  main_power_ok, rev_start_cmd, fwd_start_cmd};
      sync2_r <= sync1_r;
    end
  end

  logic fwd_s; // Synced forward start
  logic rev_s; // Synced reverse start
  logic pwr_s; // Main power established
  logic son_s; // Servo on
  logic stop_s; // Forced stop or alarm
  assign fwd_s = sync2_r[0];
  assign rev_s = sync2_r[1];
  assign pwr_s = sync2_r[2];
  assign son_s = sync2_r[3];
  assign stop_s = sync2_r[4] | sync2_r[5];

  logic [1:0] pause_sync_r; // Pause pin synchroniser

  // Pause pin has its own pair
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pause_sync_r <= 2'b00;
    else
      pause_sync_r <= {pause_sync_r[0], pause_restart_cmd};
  end

  // Previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_q_r <= 1'b0;
      rev_q_r <= 1'b0;
      pause_q_r <= 1'b0;
    end
    else
    begin
      fwd_q_r <= fwd_s;
      rev_q_r <= rev_s;
      pause_q_r <= pause_sync_r[1];
    end
  end

  logic fwd_edge; // Off-to-on forward
  logic rev_edge; // Off-to-on reverse
  assign fwd_edge = fwd_s & ~fwd_q_r;
  assign rev_edge = rev_s & ~rev_q_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] thresh_r; // Standstill threshold
  logic [15:0] settle_r; // In-position range
  logic [15:0] coarse_r; // Coarse match range
  sph_flags_t flags_r; // Reported flags
  sph_state_t state_r; // Move sequencer

  logic wr_en; // Write at access phase
  assign wr_en = psel & penable & pwrite;

  // Software writes to parameters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thresh_r <= SPH_THRESH_RST;
      settle_r <= SPH_SETTLE_RST;
      coarse_r <= SPH_COARSE_RST;
    end
    else if (wr_en)
    begin
      if (paddr == SPH_OFS_THRESH)
        thresh_r <= pwdata[15:0];
      if (paddr == SPH_OFS_SETTLE)
        settle_r <= pwdata[15:0];
      if (paddr == SPH_OFS_COARSE)
        coarse_r <= pwdata[15:0];
    end
  end

  logic mapped; // Address hits a register
  assign mapped = (paddr == SPH_OFS_THRESH) | (paddr == SPH_OFS_SETTLE) |
                  (paddr == SPH_OFS_COARSE) | (paddr == SPH_OFS_STATUS);

  // Zero-wait slave; error only on access phase to a hole
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read data registered at the setup cycle so it stands in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        SPH_OFS_THRESH: prdata <= {16'h0000, thresh_r};
        SPH_OFS_SETTLE: prdata <= {16'h0000, settle_r};
        SPH_OFS_COARSE: prdata <= {16'h0000, coarse_r};
        SPH_OFS_STATUS: prdata <= {24'h000000, state_r == SPH_RUN,
                                   gain_switch_active, pwr_s, son_s,
                                   flags_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Move sequencer
  // ----------------------------------------------------------------
  logic accept; // A start edge is taken
  // no start before power; not while running
  assign accept = (fwd_edge | rev_edge) & pwr_s & son_s &
                  (state_r == SPH_IDLE);

  // State: idle, running, halted by servo-off or stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= SPH_IDLE;
    else
    begin
      case (state_r)
        SPH_IDLE:
        begin
          if (accept)
            state_r <= SPH_RUN;
        end
        SPH_RUN:
        begin
          // Abnormal stop parks the sequence
          if (!son_s | stop_s)
            state_r <= SPH_HALT;
          else if (move_finished & sph_within(pos_deviation, settle_r))
            state_r <= SPH_IDLE;
        end
        SPH_HALT:
        begin
          if (son_s & ~stop_s)
            state_r <= SPH_IDLE;
        end
        default: state_r <= SPH_IDLE;
      endcase
    end
  end

  // One-cycle start strobes to the motion loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_fwd <= 1'b0;
      start_rev <= 1'b0;
    end
    else
    begin
      start_fwd <= accept & fwd_edge;
      start_rev <= accept & ~fwd_edge;
    end
  end

  // Pause/restart: each rising edge toggles while running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pause_toggle <= 1'b0;
    else
      pause_toggle <= pause_sync_r[1] & ~pause_q_r & (state_r == SPH_RUN);
  end

  assign busy = (state_r == SPH_RUN);

  // ----------------------------------------------------------------
  // Completion flags
  // ----------------------------------------------------------------
  logic coarse_hit; // Coarse condition now
  logic done_hit; // Done condition now
  assign coarse_hit = move_finished |
                      ((coarse_r != 16'h0000) & sph_within(remain_dist, coarse_r));
  assign done_hit = move_finished & sph_within(pos_deviation, settle_r);

  // Flags clear on servo off or a new start, all set when a halt ends; while running done and coarse set on their condition, settled follows the range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r.done <= 1'b0;
      flags_r.coarse <= 1'b0;
      flags_r.settled <= 1'b0;
    end
    else if (!son_s)
    begin
      flags_r.done <= 1'b0;
      flags_r.coarse <= 1'b0;
      flags_r.settled <= 1'b0;
    end
    else if (state_r == SPH_HALT && !stop_s)
    begin
      flags_r.done <= 1'b1;
      flags_r.coarse <= 1'b1;
      flags_r.settled <= 1'b1;
    end
    else if (accept)
    begin
      flags_r.done <= 1'b0;
      flags_r.coarse <= 1'b0;
      flags_r.settled <= 1'b0;
    end
    else if (state_r == SPH_RUN)
    begin
      if (coarse_hit)
        flags_r.coarse <= 1'b1;
      if (done_hit)
        flags_r.done <= 1'b1;
      flags_r.settled <= sph_within(pos_deviation, settle_r);
    end
  end

  // ----------------------------------------------------------------
  // Standstill detection with hysteresis
  // ----------------------------------------------------------------
  logic [15:0] speed_mag; // Speed in either direction
  logic [16:0] off_level; // Threshold plus hysteresis
  assign speed_mag = sph_abs(motor_speed);
  assign off_level = {1'b0, thresh_r} + {1'b0, SPH_HYST};

  // Set at or below threshold, clear only at the off level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r.standstill <= 1'b0;
    else if (speed_mag <= thresh_r)
      flags_r.standstill <= 1'b1;
    else if ({1'b0, speed_mag} >= off_level)
      flags_r.standstill <= 1'b0;
  end

  assign standstill_flag = flags_r.standstill;
  assign coarse_match_flag = flags_r.coarse;
  assign move_done_flag = flags_r.done;
  assign position_settled = flags_r.settled;

  // Gain switch flag follows the change window, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_switch_active <= 1'b0;
    else
      gain_switch_active <= gain_change_busy;
  end

  // ----------------------------------------------------------------
  // Encoder pulse outputs
  // ----------------------------------------------------------------
  logic [1:0] quad_r; // Gray phase, {a, b}

  // Gray step per encoder count; direction picks order
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quad_r <= 2'b00;
    else if (enc_step)
    begin
      if (enc_ccw)
        quad_r <= {~quad_r[0], quad_r[1]};
      else
        quad_r <= {quad_r[0], ~quad_r[1]};
    end
  end

  assign quad_a_out = quad_r[1];
  assign quad_a_out_n = ~quad_r[1];
  assign quad_b_out = quad_r[0];
  assign quad_b_out_n = ~quad_r[0];

  localparam logic [16:0] IDX_LOAD = 17'(INDEX_CYC);
  logic [16:0] idx_cnt_r; // Pulse width remaining
  logic idx_on_r; // Index pulse active

  // Zero point starts a stretched pulse; retrigger restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_cnt_r <= 17'h00000;
      idx_on_r <= 1'b0;
    end
    else if (enc_zero)
    begin
      idx_cnt_r <= IDX_LOAD;
      idx_on_r <= 1'b1;
    end
    else if (idx_cnt_r > 17'h00001)
      idx_cnt_r <= idx_cnt_r - 17'h00001;
    else
    begin
      idx_cnt_r <= 17'h00000;
      idx_on_r <= 1'b0;
    end
  end

  assign index_pulse_out = ~idx_on_r;
  assign index_pulse_out_n = idx_on_r;

endmodule

// ==== sph_checker.sv ====
// Purpose: port assertions for sph_positioning
// Assumes: one pclk domain, presetn async low
// Notes: bound from tb_top
`timescale 1ns/1ps
module sph_checker
  import sph_pkg::*;
#(parameter int INDEX_CYC = 20)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic main_power_ok,
  input wire logic servo_on,
  input wire logic signed [15:0] motor_speed,
  input wire logic gain_change_busy,
  input wire logic enc_ccw,
  input wire logic start_fwd,
  input wire logic start_rev,
  input wire logic busy,
  input wire logic standstill_flag,
  input wire logic gain_switch_active,
  input wire logic coarse_match_flag,
  input wire logic move_done_flag,
  input wire logic quad_a_out,
  input wire logic quad_b_out,
  input wire logic index_pulse_out,
  input wire logic index_pulse_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low time of index, counter avoids a long repetition
  int low_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_r <= 0;
    else
      low_r <= index_pulse_out ? 0 : low_r + 1;
  property p_ss; motor_speed == 16'sh0000 |=> standstill_flag; endproperty
  a_ss: assert property (p_ss) else $error("standstill missing");
  property p_gain; gain_switch_active == $past(gain_change_busy); endproperty
  a_gain: assert property (p_gain) else $error("gain flag wrong");
  property p_edge; start_fwd || start_rev |-> busy && !$past(busy); endproperty
  a_edge: assert property (p_edge) else $error("start while running");
  property p_one; start_fwd || start_rev |=> !start_fwd && !start_rev; endproperty
  a_one: assert property (p_one) else $error("start pulse long");
  property p_pwr; start_fwd || start_rev |-> main_power_ok && servo_on; endproperty
  a_pwr: assert property (p_pwr) else $error("start without power");
  property p_off; !servo_on [*4] |-> !move_done_flag && !coarse_match_flag; endproperty
  a_off: assert property (p_off) else $error("flag in servo off");
  property p_comp; index_pulse_out_n == !index_pulse_out; endproperty
  a_comp: assert property (p_comp) else $error("index pair wrong");
  property p_wid; $rose(index_pulse_out) |-> low_r >= INDEX_CYC; endproperty
  a_wid: assert property (p_wid) else $error("index too short");
  property p_ccw; enc_ccw && $rose(quad_a_out) |-> !quad_b_out; endproperty
  a_ccw: assert property (p_ccw) else $error("B not lagging");
  cover property (start_fwd);
  cover property ($rose(move_done_flag));
  cover property ($fell(index_pulse_out));
endmodule

// ==== sph_host_model.sv ====
// Purpose: host controller driving start and pause pins
// Assumes: drive_ready is power and servo on
// Notes: gated=0 lets a scenario press before ready
`timescale 1ns/1ps
module sph_host_model
#(parameter int HOLD = 8)
(
  input wire logic pclk,
  input wire logic drive_ready,
  output logic fwd_start_cmd,
  output logic rev_start_cmd,
  output logic pause_restart_cmd
);
  initial
  begin
    fwd_start_cmd = 1'h0;
    rev_start_cmd = 1'h0;
    pause_restart_cmd = 1'h0;
  end
  task automatic press(input int which, input logic gated);
    int w;
    w = 0;
    while (gated && !drive_ready && w < 1000)
    begin
      @(posedge pclk);
      w++;
    end
    @(posedge pclk);
    if (which == 0) fwd_start_cmd <= 1'h1;
    else if (which == 1) rev_start_cmd <= 1'h1;
    else pause_restart_cmd <= 1'h1;
    repeat (HOLD) @(posedge pclk);
    fwd_start_cmd <= 1'h0;
    rev_start_cmd <= 1'h0;
    pause_restart_cmd <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench for sph_positioning
// Assumes: 4 ns pclk, short index count
// Notes: start pins come from the host model
`timescale 1ns/1ps
module tb_top;
  import sph_pkg::*;
  localparam int IDX = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic main_power_ok, servo_on, move_finished, gain_change_busy;
  logic enc_step, enc_ccw, enc_zero, start_fwd, start_rev, pause_toggle, busy;
  logic forced_stop_input, alarm_active;
  logic signed [15:0] motor_speed;
  logic [15:0] pos_deviation, remain_dist;
  logic fwd_start_cmd, rev_start_cmd, pause_restart_cmd, standstill_flag;
  logic gain_switch_active, coarse_match_flag, move_done_flag, position_settled;
  logic quad_a_out, quad_a_out_n, quad_b_out, quad_b_out_n;
  logic index_pulse_out, index_pulse_out_n;
  int mismatches = 0, n_checks = 0, nfwd = 0, nrev = 0, npause = 0;
  sph_positioning #(.INDEX_CYC(IDX)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fwd_start_cmd, .rev_start_cmd, .pause_restart_cmd,
    .main_power_ok, .servo_on, .forced_stop_input, .alarm_active,
    .motor_speed, .pos_deviation, .remain_dist, .move_finished,
    .gain_change_busy, .enc_step, .enc_ccw, .enc_zero, .start_fwd,
    .start_rev, .pause_toggle, .busy, .standstill_flag, .gain_switch_active,
    .coarse_match_flag, .move_done_flag, .position_settled, .quad_a_out,
    .quad_a_out_n, .quad_b_out, .quad_b_out_n, .index_pulse_out,
    .index_pulse_out_n
  );
  sph_host_model #(.HOLD(8)) u_host (
    .pclk, .drive_ready(main_power_ok & servo_on), .fwd_start_cmd,
    .rev_start_cmd, .pause_restart_cmd
  );
  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // Count start pulses
  always @(posedge pclk)
  begin
    if (start_fwd === 1'h1) nfwd++;
    if (start_rev === 1'h1) nrev++;
    if (pause_toggle === 1'h1) npause++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++t < 50);
    // A slave that never answers ends the run
    if (pready !== 1'h1)
    begin
      mismatches++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic t_regs();
    rdchk(SPH_OFS_THRESH, 32'h32);
    rdchk(SPH_OFS_COARSE, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    check(err, 32'h1);
    apb(1'h1, SPH_OFS_THRESH, 32'h1234_000a);
    rdchk(SPH_OFS_THRESH, 32'ha);
  endtask
  task automatic spd(input logic signed [15:0] s, input logic e);
    motor_speed <= s;
    repeat (3) @(posedge pclk);
    check(standstill_flag, e);
  endtask
  // Hysteresis at threshold 10, then at 50
  task automatic t_still();
    spd(16'sh001e, 1'h0);
    spd(16'sh000a, 1'h1);
    spd(16'sh001d, 1'h1);
    spd(-16'sh001e, 1'h0);
    spd(-16'sh000a, 1'h1);
    apb(1'h1, SPH_OFS_THRESH, 32'h32);
    spd(-16'sh0046, 1'h0);
    spd(16'sh0032, 1'h1);
    spd(16'sh0045, 1'h1);
    spd(16'sh0046, 1'h0);
  endtask
  task automatic t_move();
    pos_deviation <= 16'h65;
    remain_dist <= 16'hffff;
    u_host.press(0, 1'h0);
    check(nfwd, 0);
    main_power_ok <= 1'h1;
    u_host.press(0, 1'h1);
    check({nfwd[1:0], busy}, 3'h3);
    u_host.press(1, 1'h1);
    check(nrev, 0);
    move_finished <= 1'h1;
    repeat (4) @(posedge pclk);
    check({coarse_match_flag, busy, move_done_flag}, 3'h6);
    pos_deviation <= 16'h64;
    repeat (4) @(posedge pclk);
    check({busy, move_done_flag}, 2'h1);
    move_finished <= 1'h0;
    apb(1'h1, SPH_OFS_COARSE, 32'h10);
    u_host.press(1, 1'h1);
    check({nrev[1:0], coarse_match_flag, move_done_flag}, 4'h4);
    remain_dist <= 16'h10;
    repeat (4) @(posedge pclk);
    check(coarse_match_flag, 1'h1);
    // Pause edge while running gives one toggle
    u_host.press(2, 1'h1);
    check({npause[1:0], busy}, 3'h3);
    servo_on <= 1'h0;
    repeat (6) @(posedge pclk);
    check({coarse_match_flag, move_done_flag}, 2'h0);
    // Host looks at status before resuming
    rdchk(SPH_OFS_STATUS, 32'h20);
    servo_on <= 1'h1;
    repeat (6) @(posedge pclk);
    check({busy, coarse_match_flag, move_done_flag, position_settled}, 4'h7);
    // Pause while idle must not toggle
    u_host.press(2, 1'h1);
    check(npause, 1);
  endtask
  // Halt by forced stop (0) or alarm (1), then resume
  task automatic t_stop(input logic which);
    u_host.press(0, 1'h1);
    check({busy, move_done_flag}, 2'h2);
    if (which)
      alarm_active <= 1'h1;
    else
      forced_stop_input <= 1'h1;
    repeat (6) @(posedge pclk);
    check({busy, move_done_flag}, 2'h0);
    forced_stop_input <= 1'h0;
    alarm_active <= 1'h0;
    repeat (6) @(posedge pclk);
    check({busy, coarse_match_flag, move_done_flag, position_settled}, 4'h7);
  endtask
  task automatic t_enc();
    logic [1:0] ph [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    int n;
    n = 0;
    gain_change_busy <= 1'h1;
    foreach (ph[i])
    begin
      enc_step <= 1'h1;
      @(posedge pclk);
      enc_step <= 1'h0;
      repeat (3) @(posedge pclk);
      check({quad_a_out, quad_b_out, quad_a_out_n, quad_b_out_n}, {ph[i], ~ph[i]});
    end
    // Clockwise step: A lags B
    enc_ccw <= 1'h0;
    enc_step <= 1'h1;
    @(posedge pclk);
    enc_step <= 1'h0;
    repeat (3) @(posedge pclk);
    check({quad_a_out, quad_b_out}, 2'h1);
    check(gain_switch_active, 1'h1);
    gain_change_busy <= 1'h0;
    // creep speed while homing on index
    motor_speed <= 16'sh0064;
    enc_zero <= 1'h1;
    @(posedge pclk);
    enc_zero <= 1'h0;
    repeat (IDX + 8) @(posedge pclk) n += (index_pulse_out === 1'h0);
    check(n, IDX);
    check({gain_switch_active, index_pulse_out_n}, 2'h0);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, main_power_ok, move_finished} = '0;
    {gain_change_busy, enc_step, enc_zero, paddr, pwdata} = '0;
    {forced_stop_input, alarm_active} = '0;
    {motor_speed, pos_deviation, remain_dist} = '0;
    servo_on = 1'h1;
    enc_ccw = 1'h1;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_still();
    t_move();
    t_stop(1'h0);
    t_stop(1'h1);
    t_enc();
    stop_test();
  end
  // Hang guard, run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule
bind sph_positioning sph_checker #(.INDEX_CYC(INDEX_CYC)) u_chk (
  .pclk, .presetn, .main_power_ok, .servo_on, .motor_speed, .gain_change_busy,
  .enc_ccw, .start_fwd, .start_rev, .busy, .standstill_flag,
  .gain_switch_active, .coarse_match_flag, .move_done_flag, .quad_a_out,
  .quad_b_out, .index_pulse_out, .index_pulse_out_n
);
